// [rtl/isp_pkg.sv]
// Constants, register layout and helper functions of the interrupt source prioritizer.
// Assumes a 16-bit register set reached over a 32-bit bus with word-aligned registers.
package isp_pkg;

	// --------------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------------
	localparam int ISP_NSRC = 13;
	localparam int ISP_NSLOT = 15;
	localparam int ISP_NLVL = 5;
	localparam int ISP_AW = 10;

	typedef logic [15:0] isp_reg_t;
	typedef logic [2:0] isp_lvl_t;
	typedef logic [3:0] isp_slot_t;
	typedef logic [3:0] isp_src_t;

	// --------------------------------------------------------------------
	// Register slots, word indices and writable bits
	// --------------------------------------------------------------------
	localparam int SL_EXT_FLAG = 0;
	localparam int SL_WD_CTRL = 1;
	localparam int SL_EXT_EN = 2;
	localparam int SL_IRQ_EN = 3;
	localparam int SL_PRIO_LO = 4;
	localparam int SL_PRIO_HI = 5;
	localparam int SL_EPRIO_LO = 6;
	localparam int SL_EPRIO_HI = 7;
	localparam int SL_T01_CTRL = 8;
	localparam int SL_T2_CTRL = 9;
	localparam int SL_SER0_CTRL = 10;
	localparam int SL_SER1_CTRL = 11;
	localparam int SL_STATUS = 12;
	localparam int SL_MASK = 13;
	localparam int SL_CORE = 14;

	localparam logic [7:0] ISP_IDX [ISP_NSLOT] = '{
		8'h91, 8'hd8, 8'he8, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
	localparam isp_reg_t ISP_WMASK [ISP_NSLOT] = '{
		16'h00ff, 16'h00ff, 16'h001f, 16'h00ff, 16'h007f, 16'h007f, 16'h001f, 16'h001f,
		16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h1fff, 16'h1fff, 16'h0000};
	localparam isp_reg_t ISP_RST = 16'h0000;

	// --------------------------------------------------------------------
	// Bit positions
	// --------------------------------------------------------------------
	localparam int B_PF_FLAG = 4;
	localparam int B_PF_EN = 5;
	localparam int B_WD_FLAG = 3;
	localparam int B_EXT2_FLAG = 4;
	localparam int B_GATE = 7;
	localparam int B_EXT0_EDGE = 0;
	localparam int B_EXT0_FLAG = 1;
	localparam int B_EXT1_EDGE = 2;
	localparam int B_EXT1_FLAG = 3;
	localparam int B_T0_FLAG = 5;
	localparam int B_T1_FLAG = 7;
	localparam int B_T2_OVF = 7;
	localparam int B_T2_EXT = 6;
	localparam int B_RX_FLAG = 0;
	localparam int B_TX_FLAG = 1;
	localparam int B_CORE_ACT = 8;

	// --------------------------------------------------------------------
	// Sources in natural order, vectors, levels
	// --------------------------------------------------------------------
	localparam int SRC_PF = 0;
	localparam int SRC_EXT0 = 1;
	localparam int SRC_T0 = 2;
	localparam int SRC_EXT1 = 3;
	localparam int SRC_T1 = 4;
	localparam int SRC_SER0 = 5;
	localparam int SRC_T2 = 6;
	localparam int SRC_SER1 = 7;
	localparam int SRC_EXT2 = 8;
	localparam int SRC_WD = 12;
	localparam int ISP_NEXT_HI = 4;

	localparam logic [7:0] ISP_VEC [ISP_NSRC] = '{
		8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
		8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
	localparam isp_lvl_t ISP_LVL_PF = 3'h4;

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	function automatic isp_slot_t isp_slot_of(input logic [7:0] idx);
		isp_slot_of = isp_slot_t'(ISP_NSLOT);
		for (int k = 0; k < ISP_NSLOT; k++) begin
			if (ISP_IDX[k] == idx) begin
				isp_slot_of = isp_slot_t'(k);
			end
		end
	endfunction

	// Raw request flag of every source, as seen in a register image
	function automatic logic [ISP_NSRC-1:0] isp_flags(input isp_reg_t r [ISP_NSLOT]);
		logic [ISP_NSRC-1:0] f;
		f = '0;
		f[SRC_PF] = r[SL_WD_CTRL][B_PF_FLAG];
		f[SRC_EXT0] = r[SL_T01_CTRL][B_EXT0_FLAG];
		f[SRC_T0] = r[SL_T01_CTRL][B_T0_FLAG];
		f[SRC_EXT1] = r[SL_T01_CTRL][B_EXT1_FLAG];
		f[SRC_T1] = r[SL_T01_CTRL][B_T1_FLAG];
		f[SRC_SER0] = r[SL_SER0_CTRL][B_RX_FLAG] | r[SL_SER0_CTRL][B_TX_FLAG];
		f[SRC_T2] = r[SL_T2_CTRL][B_T2_OVF] | r[SL_T2_CTRL][B_T2_EXT];
		f[SRC_SER1] = r[SL_SER1_CTRL][B_RX_FLAG] | r[SL_SER1_CTRL][B_TX_FLAG];
		for (int j = 0; j < ISP_NEXT_HI; j++) begin
			f[SRC_EXT2 + j] = r[SL_EXT_FLAG][B_EXT2_FLAG + j];
		end
		f[SRC_WD] = r[SL_WD_CTRL][B_WD_FLAG];
		return f;
	endfunction

	// Highest level currently in service
	function automatic isp_lvl_t isp_top(input logic [ISP_NLVL-1:0] act);
		isp_top = '0;
		for (int k = 0; k < ISP_NLVL; k++) begin
			if (act[k]) begin
				isp_top = isp_lvl_t'(k);
			end
		end
	endfunction

endpackage

// [rtl/isp_res_if.sv]
// Carrier between the prioritizer top and its level resolver.
// Assumes both ends sit in the same clock domain; the resolver is purely combinational.
`timescale 1ns/1ps
interface isp_res_if;
	import isp_pkg::*;
	logic [ISP_NSRC-1:0] pend;
	isp_lvl_t lvl [ISP_NSRC];
	logic win_valid;
	isp_src_t win_idx;
	isp_lvl_t win_lvl;
	modport ctl(output pend, output lvl, input win_valid, input win_idx, input win_lvl);
	modport res(input pend, input lvl, output win_valid, output win_idx, output win_lvl);
endinterface

// [rtl/isp_resolver.sv]
// Picks the pending source of highest level, earliest in natural order on a tie.
// Assumes pend and lvl are stable within the cycle.
`timescale 1ns/1ps
module isp_resolver (
	// Request set and answer
	isp_res_if.res rif
);
	import isp_pkg::*;

	logic valid;
	isp_src_t idx;
	isp_lvl_t lvl;

	always_comb begin
		valid = 1'b0;
		idx = '0;
		lvl = '0;
		// Strictly greater keeps the earlier source on equal level
		for (int i = 0; i < ISP_NSRC; i++) begin
			if (rif.pend[i] && (!valid || rif.lvl[i] > lvl)) begin
				valid = 1'b1;
				idx = isp_src_t'(i);
				lvl = rif.lvl[i];
			end
		end
	end

	assign rif.win_valid = valid;
	assign rif.win_idx = idx;
	assign rif.win_lvl = lvl;

endmodule

// [rtl/isp_top.sv]
// Interrupt source prioritizer: thirteen sources, five levels, Avalon-MM register slave.
// Assumes event inputs are one-cycle pulses and pins are synchronous to clk.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// Summary of operation
// - Each source has its own fixed vector
// - Natural order power-fail first, watchdog last
// - Power-fail flag/enable in watchdog control, no priority
// - Two priority bits per source at enable position
// - Serial receive or transmit flag requests vector
// - Timer2 overflow or external flag requests vector
// - Ext2-5 flags, enables, priorities in extended registers
// - Watchdog uses its flag, enable, priority bits
// - Flags set regardless of enable bits
// - Timer0/1 flags clear on vectoring
// - Edge external 0/1 flags clear on vectoring
// - Level external 0/1 flags follow the pin
// - Global gate blocks all except power-fail
// - Power-fail gated only by its own enable
// - Five levels, level 4 power-fail only
// - Equal level resolved by natural order
module isp_top (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [isp_pkg::ISP_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Processor core
	output logic core_irq_req,
	output logic [7:0] core_irq_vector,
	output isp_pkg::isp_lvl_t core_irq_level,
	input wire logic core_vector_ack,
	input wire logic core_reti,
	// Source events and pins
	input wire logic ev_power_fail,
	input wire logic ext0_in,
	input wire logic ext1_in,
	input wire logic ev_timer0_ovf,
	input wire logic ev_timer1_ovf,
	input wire logic ev_timer2_ovf,
	input wire logic ev_timer2_ext,
	input wire logic ev_serial0_rx,
	input wire logic ev_serial0_tx,
	input wire logic ev_serial1_rx,
	input wire logic ev_serial1_tx,
	input wire logic [isp_pkg::ISP_NEXT_HI-1:0] ev_ext_hi,
	input wire logic ev_watchdog,
	// Summary interrupt
	output logic irq
);
	import isp_pkg::*;

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	isp_reg_t regs_r [ISP_NSLOT];
	isp_reg_t regs_nxt [ISP_NSLOT];
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] ext_prev_r, ext_prev_nxt;
	logic [ISP_NLVL-1:0] act_r, act_nxt;
	logic req_r, req_nxt;
	logic [7:0] vec_r, vec_nxt;
	isp_lvl_t lvl_r, lvl_nxt;
	isp_src_t src_r, src_nxt;

	isp_res_if rif();

	isp_resolver u_res (
		.rif(rif)
	);

	// --------------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------------
	logic bus_req;
	isp_slot_t slot;
	logic hit;
	logic wr;
	isp_reg_t lane_m;
	isp_reg_t wm;
	isp_reg_t wd;
	logic take;
	logic [ISP_NSRC-1:0] flags;
	logic [ISP_NSRC-1:0] stat_set;
	logic ext0_edge, ext1_edge;
	logic grant;

	assign bus_req = avs_read | avs_write;
	// Fixed single wait state: read data is registered on the edge that raises ack
	assign avs_waitrequest = bus_req & ~ack_r;
	assign slot = isp_slot_of(avs_address[ISP_AW-1:2]);
	assign hit = (slot != isp_slot_t'(ISP_NSLOT));
	assign wr = ack_r & avs_write & hit;
	assign lane_m = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wd = avs_writedata[15:0];
	assign wm = hit ? (ISP_WMASK[slot] & lane_m) : '0;
	assign take = core_vector_ack & req_r;

	always_comb begin
		ack_nxt = bus_req & ~ack_r;
		rdata_nxt = rdata_r;
		if (ack_nxt && avs_read) begin
			if (!hit) begin
				rdata_nxt = '0;
			end else if (slot == isp_slot_t'(SL_CORE)) begin
				rdata_nxt = {16'h0000, 3'h0, act_r, vec_r};
			end else begin
				rdata_nxt = {16'h0000, regs_r[slot]};
			end
		end
	end

	// --------------------------------------------------------------------
	// Register file and flags
	// --------------------------------------------------------------------
	assign ext0_edge = ext0_in & ~ext_prev_r[0];
	assign ext1_edge = ext1_in & ~ext_prev_r[1];

	always_comb begin
		ext_prev_nxt = {ext1_in, ext0_in};
		for (int k = 0; k < ISP_NSLOT; k++) begin
			regs_nxt[k] = regs_r[k];
		end
		// Software writes; flags not cleared by hardware are cleared here
		if (wr && slot == isp_slot_t'(SL_STATUS)) begin
			regs_nxt[SL_STATUS] = regs_r[SL_STATUS] & ~(wd & wm);
		end else if (wr) begin
			regs_nxt[slot] = (regs_r[slot] & ~wm) | (wd & wm);
		end
		// Clear on vectoring
		if (take && src_r == isp_src_t'(SRC_T0)) begin
			regs_nxt[SL_T01_CTRL][B_T0_FLAG] = 1'b0;
		end
		if (take && src_r == isp_src_t'(SRC_T1)) begin
			regs_nxt[SL_T01_CTRL][B_T1_FLAG] = 1'b0;
		end
		if (take && src_r == isp_src_t'(SRC_EXT0) && regs_r[SL_T01_CTRL][B_EXT0_EDGE]) begin
			regs_nxt[SL_T01_CTRL][B_EXT0_FLAG] = 1'b0;
		end
		if (take && src_r == isp_src_t'(SRC_EXT1) && regs_r[SL_T01_CTRL][B_EXT1_EDGE]) begin
			regs_nxt[SL_T01_CTRL][B_EXT1_FLAG] = 1'b0;
		end
		// Hardware sets come last so they win, whatever the enables
		if (ev_power_fail) begin
			regs_nxt[SL_WD_CTRL][B_PF_FLAG] = 1'b1;
		end
		if (ev_watchdog) begin
			regs_nxt[SL_WD_CTRL][B_WD_FLAG] = 1'b1;
		end
		for (int j = 0; j < ISP_NEXT_HI; j++) begin
			if (ev_ext_hi[j]) begin
				regs_nxt[SL_EXT_FLAG][B_EXT2_FLAG + j] = 1'b1;
			end
		end
		if (ev_timer0_ovf) begin
			regs_nxt[SL_T01_CTRL][B_T0_FLAG] = 1'b1;
		end
		if (ev_timer1_ovf) begin
			regs_nxt[SL_T01_CTRL][B_T1_FLAG] = 1'b1;
		end
		if (ev_timer2_ovf) begin
			regs_nxt[SL_T2_CTRL][B_T2_OVF] = 1'b1;
		end
		if (ev_timer2_ext) begin
			regs_nxt[SL_T2_CTRL][B_T2_EXT] = 1'b1;
		end
		if (ev_serial0_rx) begin
			regs_nxt[SL_SER0_CTRL][B_RX_FLAG] = 1'b1;
		end
		if (ev_serial0_tx) begin
			regs_nxt[SL_SER0_CTRL][B_TX_FLAG] = 1'b1;
		end
		if (ev_serial1_rx) begin
			regs_nxt[SL_SER1_CTRL][B_RX_FLAG] = 1'b1;
		end
		if (ev_serial1_tx) begin
			regs_nxt[SL_SER1_CTRL][B_TX_FLAG] = 1'b1;
		end
		// External 0/1: latch an edge, or follow the pin in level mode
		if (!regs_nxt[SL_T01_CTRL][B_EXT0_EDGE]) begin
			regs_nxt[SL_T01_CTRL][B_EXT0_FLAG] = ext0_in;
		end else if (ext0_edge) begin
			regs_nxt[SL_T01_CTRL][B_EXT0_FLAG] = 1'b1;
		end
		if (!regs_nxt[SL_T01_CTRL][B_EXT1_EDGE]) begin
			regs_nxt[SL_T01_CTRL][B_EXT1_FLAG] = ext1_in;
		end else if (ext1_edge) begin
			regs_nxt[SL_T01_CTRL][B_EXT1_FLAG] = 1'b1;
		end
		// Sticky status follows each rising flag, set over write-one clear
		stat_set = isp_flags(regs_nxt) & ~isp_flags(regs_r);
		regs_nxt[SL_STATUS][ISP_NSRC-1:0] = regs_nxt[SL_STATUS][ISP_NSRC-1:0] | stat_set;
	end

	// Level output, high while any unmasked sticky status bit is set
	assign irq = |(regs_r[SL_STATUS] & regs_r[SL_MASK]);

	// --------------------------------------------------------------------
	// Pending sources and levels
	// --------------------------------------------------------------------
	assign flags = isp_flags(regs_r);

	always_comb begin
		rif.pend = '0;
		for (int i = 0; i < ISP_NSRC; i++) begin
			rif.lvl[i] = '0;
		end
		// Power-fail ignores the global gate and sits alone on the top level
		rif.pend[SRC_PF] = flags[SRC_PF] & regs_r[SL_WD_CTRL][B_PF_EN];
		rif.lvl[SRC_PF] = ISP_LVL_PF;
		for (int i = SRC_EXT0; i < SRC_EXT2; i++) begin
			rif.pend[i] = flags[i] & regs_r[SL_IRQ_EN][i-1] & regs_r[SL_IRQ_EN][B_GATE];
			rif.lvl[i] = {1'b0, regs_r[SL_PRIO_HI][i-1], regs_r[SL_PRIO_LO][i-1]};
		end
		for (int i = SRC_EXT2; i < ISP_NSRC; i++) begin
			rif.pend[i] = flags[i] & regs_r[SL_EXT_EN][i-SRC_EXT2]
				& regs_r[SL_IRQ_EN][B_GATE];
			rif.lvl[i] = {1'b0, regs_r[SL_EPRIO_HI][i-SRC_EXT2],
				regs_r[SL_EPRIO_LO][i-SRC_EXT2]};
		end
	end

	// --------------------------------------------------------------------
	// Core request and levels in service
	// --------------------------------------------------------------------
	isp_lvl_t top_lvl;

	// Highest level in service; only a strictly higher winner may interrupt it
	assign top_lvl = isp_top(act_r);
	assign grant = rif.win_valid && (act_r == '0 || rif.win_lvl > top_lvl);

	always_comb begin
		act_nxt = act_r;
		if (core_reti && act_r != '0) begin
			act_nxt[top_lvl] = 1'b0;
		end
		if (take) begin
			act_nxt[lvl_r] = 1'b1;
		end
		// Drop the request for one cycle after a take so it is not taken twice
		req_nxt = grant & ~take;
		// With no winner the vector reads as zero rather than a stale table entry
		vec_nxt = '0;
		lvl_nxt = '0;
		src_nxt = '0;
		if (rif.win_valid) begin
			vec_nxt = ISP_VEC[rif.win_idx];
			lvl_nxt = rif.win_lvl;
			src_nxt = rif.win_idx;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int k = 0; k < ISP_NSLOT; k++) begin
				regs_r[k] <= ISP_RST;
			end
			ack_r <= 1'b0;
			rdata_r <= '0;
			ext_prev_r <= '0;
			act_r <= '0;
			req_r <= 1'b0;
			vec_r <= '0;
			lvl_r <= '0;
			src_r <= '0;
		end else begin
			for (int k = 0; k < ISP_NSLOT; k++) begin
				regs_r[k] <= regs_nxt[k];
			end
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			ext_prev_r <= ext_prev_nxt;
			act_r <= act_nxt;
			req_r <= req_nxt;
			vec_r <= vec_nxt;
			lvl_r <= lvl_nxt;
			src_r <= src_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign core_irq_req = req_r;
	assign core_irq_vector = vec_r;
	assign core_irq_level = lvl_r;

endmodule

// [tb/isp_props.sv]
// Checker of the prioritizer ports: bus handshake, vector, level and nesting relations.
// Assumes it is bound onto isp_top; one clock domain.
`timescale 1ns/1ps
module isp_props (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Core and summary
	input wire logic core_irq_req,
	input wire logic [7:0] core_irq_vector,
	input wire isp_pkg::isp_lvl_t core_irq_level,
	input wire logic core_vector_ack,
	input wire logic core_reti,
	input wire logic irq
);
	import isp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_vec;
		core_irq_req |-> core_irq_vector inside {8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
			8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
	endproperty
	property p_pf_lvl;
		core_irq_req && core_irq_vector == 8'h33 |-> core_irq_level == 3'h4;
	endproperty
	property p_lvl;
		core_irq_req && core_irq_vector != 8'h33 |-> core_irq_level <= 3'h3;
	endproperty
	property p_ack_drop;
		core_irq_req && core_vector_ack |=> !core_irq_req;
	endproperty
	property p_preempt;
		core_irq_req && core_vector_ack ##1 !core_reti
			|=> !core_irq_req || core_irq_level > $past(core_irq_level, 2);
	endproperty
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_idle;
		!(avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	property p_rdata;
		!(avs_read && avs_waitrequest)
			|=> $stable(avs_readdata) && avs_readdata[31:16] == 16'h0000;
	endproperty
	a_vec: assert property (p_vec) else $error("vector outside table");
	a_pf_lvl: assert property (p_pf_lvl) else $error("power-fail level wrong");
	a_lvl: assert property (p_lvl) else $error("level above 3");
	a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
	a_preempt: assert property (p_preempt) else $error("preempt not higher");
	a_wait: assert property (p_wait) else $error("wait state too long");
	a_idle: assert property (p_idle) else $error("wait without request");
	a_rdata: assert property (p_rdata) else $error("read data changed or upper bits set");
	c_pf: cover property (core_vector_ack && core_irq_vector == 8'h33);
	c_nest: cover property (core_vector_ack && core_irq_level == 3'h3);
	c_irq: cover property ($rose(irq));
endmodule

bind isp_top isp_props u_props (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
	.core_irq_level(core_irq_level), .core_vector_ack(core_vector_ack),
	.core_reti(core_reti), .irq(irq));

// [tb/isp_core_model.sv]
// Processor core model: takes a standing vector request and returns from routines.
// Assumes a registered request from the prioritizer on the same clock.
`timescale 1ns/1ps
module isp_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Prioritizer side
	input wire logic core_irq_req,
	input wire logic [7:0] core_irq_vector,
	output logic core_vector_ack,
	output logic core_reti,
	// Bench control
	input wire logic accept,
	input wire logic [3:0] ack_delay,
	input wire logic ret_req,
	output logic [7:0] taken_vec,
	output logic [7:0] n_taken
);
	logic [3:0] wait_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core_vector_ack <= 1'b0;
			core_reti <= 1'b0;
			wait_r <= 4'h0;
			taken_vec <= 8'h00;
			n_taken <= 8'h00;
		end else begin
			core_reti <= ret_req;
			core_vector_ack <= 1'b0;
			wait_r <= 4'h0;
			// Record the vector standing at the edge where the ack is sampled
			if (core_vector_ack && core_irq_req) begin
				taken_vec <= core_irq_vector;
				n_taken <= n_taken + 8'h01;
			end
			// Ack only a standing request, never in two cycles running
			if (accept && core_irq_req && !core_vector_ack) begin
				if (wait_r >= ack_delay) begin
					core_vector_ack <= 1'b1;
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end
		end
	end
endmodule

// [tb/isp_top_tb.sv]
// Bench: registers, sources, gating, priority and nesting of the prioritizer.
// Assumes the core model and checker are compiled first.
`timescale 1ns/1ps
module isp_top_tb;
	import isp_pkg::*;
	localparam logic [7:0] VEC_TAB [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
		8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, alt, accept, ret_req;
	logic core_irq_req, core_vector_ack, core_reti;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] core_irq_vector, taken_vec, n_taken, cnt;
	logic [12:0] ev;
	logic [1:0] pins;
	logic [3:0] ack_delay;
	logic [15:0] q;
	isp_lvl_t core_irq_level;
	int n_mismatch, samples_checked, cycles;
	isp_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
		.core_irq_level(core_irq_level), .core_vector_ack(core_vector_ack),
		.core_reti(core_reti), .ev_power_fail(ev[0]), .ext0_in(pins[0]), .ext1_in(pins[1]),
		.ev_timer0_ovf(ev[2]), .ev_timer1_ovf(ev[4]), .ev_timer2_ovf(ev[6] & ~alt),
		.ev_timer2_ext(ev[6] & alt), .ev_serial0_rx(ev[5] & ~alt), .ev_serial0_tx(ev[5] & alt),
		.ev_serial1_rx(ev[7] & ~alt), .ev_serial1_tx(ev[7] & alt), .ev_ext_hi(ev[11:8]),
		.ev_watchdog(ev[12]), .irq(irq));
	isp_core_model u_core (.clk(clk), .sys_rst(sys_rst), .core_irq_req(core_irq_req),
		.core_irq_vector(core_irq_vector), .core_vector_ack(core_vector_ack),
		.core_reti(core_reti), .accept(accept), .ack_delay(ack_delay), .ret_req(ret_req),
		.taken_vec(taken_vec), .n_taken(n_taken));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bus access; entered right after a rising edge, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] d);
		avs_address <= {i, 2'b00};
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic fire(input logic [12:0] m);
		ev <= m;
		pins <= {m[3], m[1]};
		@(posedge clk);
		ev <= '0;
		pins <= '0;
	endtask
	task automatic take(input logic [7:0] v);
		do begin
			@(negedge clk);
		end while (n_taken === cnt);
		cnt = n_taken;
		chk({8'h00, taken_vec}, {8'h00, v});
		@(posedge clk);
	endtask
	task automatic ret;
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		@(posedge clk);
	endtask
	// Software clears the flags that hardware leaves set
	task automatic clr;
		acc(1, ISP_IDX[SL_T2_CTRL], 16'h0000);
		acc(1, ISP_IDX[SL_SER0_CTRL], 16'h0000);
		acc(1, ISP_IDX[SL_SER1_CTRL], 16'h0000);
		acc(1, ISP_IDX[SL_EXT_FLAG], 16'h0000);
		acc(1, ISP_IDX[SL_WD_CTRL], 16'h0020);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			finish_test;
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{sys_rst, avs_read, avs_write, alt, accept, ret_req} = 6'b100000;
		{avs_address, avs_writedata, ev, pins, ack_delay, cnt} = '0;
		{n_mismatch, samples_checked, cycles} = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < ISP_NSLOT; k++) begin
			acc(0, ISP_IDX[k], 16'h0000);
			chk(q, 16'h0000);
		end
		acc(0, 8'h20, 16'h0000);
		chk(q, 16'h0000);
		for (int k = 0; k < 14; k++) begin
			if (k != SL_STATUS) begin
				acc(1, ISP_IDX[k], 16'hffff);
				acc(0, ISP_IDX[k], 16'h0000);
				chk(q, ISP_WMASK[k]);
				acc(1, ISP_IDX[k], 16'h0000);
			end
		end
		acc(1, ISP_IDX[SL_STATUS], 16'h1fff);
		pins <= 2'b01;
		repeat (3) @(posedge clk);
		acc(0, ISP_IDX[SL_T01_CTRL], 16'h0000);
		chk(q, 16'h0002);
		pins <= 2'b00;
		repeat (3) @(posedge clk);
		acc(0, ISP_IDX[SL_T01_CTRL], 16'h0000);
		chk(q, 16'h0000);
		acc(1, ISP_IDX[SL_IRQ_EN], 16'h0008);
		fire(13'h0010);
		acc(0, ISP_IDX[SL_T01_CTRL], 16'h0000);
		chk(q, 16'h0080);
		acc(0, ISP_IDX[SL_STATUS], 16'h0000);
		chk(q, 16'h0012);
		chk({15'h0, irq}, 16'h0000);
		chk({15'h0, core_irq_req}, 16'h0000);
		acc(1, ISP_IDX[SL_MASK], 16'h0010);
		chk({15'h0, irq}, 16'h0001);
		acc(1, ISP_IDX[SL_STATUS], 16'h0010);
		chk({15'h0, irq}, 16'h0000);
		$display("test regs done");
		acc(1, ISP_IDX[SL_WD_CTRL], 16'h0020);
		accept <= 1'b1;
		fire(13'h0001);
		take(8'h33);
		acc(1, ISP_IDX[SL_WD_CTRL], 16'h0020);
		ret;
		$display("test power-fail done");
		acc(1, ISP_IDX[SL_T01_CTRL], 16'h0005);
		acc(1, ISP_IDX[SL_IRQ_EN], 16'h00ff);
		acc(1, ISP_IDX[SL_EXT_EN], 16'h001f);
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 13; s++) begin
				alt <= p[0];
				fire(13'h0001 << s);
				take(VEC_TAB[s]);
				acc(0, ISP_IDX[SL_T01_CTRL], 16'h0000);
				chk(q, 16'h0005);
				clr;
				ret;
				chk({15'h0, core_irq_req}, 16'h0000);
			end
		end
		$display("test sources done");
		ack_delay <= 4'h3;
		acc(1, ISP_IDX[SL_PRIO_LO], 16'h0008);
		acc(1, ISP_IDX[SL_EPRIO_LO], 16'h0001);
		acc(1, ISP_IDX[SL_EPRIO_HI], 16'h0011);
		fire(13'h1010);
		take(8'h63);
		fire(13'h0004);
		repeat (10) @(posedge clk);
		chk({8'h00, n_taken}, {8'h00, cnt});
		fire(13'h0100);
		take(8'h43);
		clr;
		ret;
		ret;
		take(8'h1b);
		ret;
		take(8'h0b);
		ret;
		ack_delay <= 4'h0;
		fire(13'h00a0);
		take(8'h23);
		clr;
		ret;
		$display("test priority done");
		finish_test;
	end
endmodule
